// ==== common/lmc_map.vh ====
`ifndef LMC_MAP_VH
`define LMC_MAP_VH
// register indices; byte address is four times the index
`define LMC_IDX_CTL0      12'hF42
`define LMC_IDX_CTL1      12'hF43
`define LMC_IDX_STAT      12'hF44
`define LMC_IDX_MASK      12'hF45
`define LMC_IDX_RLD_HI    12'hF46
`define LMC_IDX_RLD_LO    12'hF47
// control-0 fields
`define LMC_C0_MULTIPROC_ENABLE       7
`define LMC_C0_PEN        6
`define LMC_C0_SEL_HI     2
`define LMC_C0_SEL_LO     0
// page select code that exposes the lin control register
`define LMC_PAGE_LIN      3'h2
// control-1 (lin page) fields
`define LMC_C1_MST        7
`define LMC_C1_SLV        6
`define LMC_C1_AUTO_RATE_ENABLE       5
`define LMC_C1_AUTO_RATE_IRQ_ENABLE      4
`define LMC_C1_ST_HI      3
`define LMC_C1_ST_LO      2
`define LMC_C1_BRK_HI     1
`define LMC_C1_BRK_LO     0
// status / mask bits
`define LMC_ST_ABDONE     0
`define LMC_ST_BRKSENT    1
`define LMC_ST_BRKSEEN    2
`define LMC_ST_W          3
// lin state codes
`define LMC_S_SLEEP       2'h0
`define LMC_S_WAITBRK     2'h1
`define LMC_S_AUTOBAUD    2'h2
`define LMC_S_ACTIVE      2'h3
// reset values
`define LMC_RST_CTL       8'h00
`define LMC_RST_RLD       16'hFFFF
// break timing in bit times
`define LMC_BRK_BASE      5'h0D
`define LMC_BRK_DETECT    5'h0B
// sync character falling edges after the start edge
`define LMC_SYNC_FALLS    3'h4
`endif

// ==== hdl/lmc_brk.v ====
`timescale 1ns/1ps
`include "lmc_map.vh"
// master break transmitter: holds the line low for 13 to 16 bit times
module lmc_brk (
   // clock and reset
   input  wire       sys_clk,
   input  wire       rst,
   // control
   input  wire       start,
   input  wire [1:0] len_sel,
   input  wire       bit_tick,
   // results
   output reg        tx,
   output reg        busy,
   output reg        done
);
   reg [4:0] left;   // bit times still to send

   // break counter, counts whole bit periods of the current rate
   always @(posedge sys_clk) begin
      if (rst) begin
         tx   <= 1'b1;
         busy <= 1'b0;
         done <= 1'b0;
         left <= 5'h00;
      end else begin
         done <= 1'b0;
         if (!busy && start) begin
            busy <= 1'b1;
            tx   <= 1'b0;
            left <= `LMC_BRK_BASE + {3'h0, len_sel};
         end else if (busy && bit_tick) begin
            if (left == 5'h01) begin
               // release line, the core datapath sends the delimiter
               busy <= 1'b0;
               tx   <= 1'b1;
               done <= 1'b1;
            end
            left <= left - 5'h01;
         end
      end
   end
endmodule

// ==== hdl/lmc_abd.v ====
`timescale 1ns/1ps
`include "lmc_map.vh"
// slave receive side: break detection and sync-character rate measurement
module lmc_abd (
   // clock and reset
   input  wire        sys_clk,
   input  wire        rst,
   // synchronised line and state
   input  wire        rx,
   input  wire        in_wait,
   input  wire        in_ab,
   input  wire        bit_tick,
   // results
   output reg         brk_seen,
   output reg         ab_done,
   output reg  [15:0] ab_period
);
   reg        rx_prev;   // line one cycle ago
   reg [4:0]  low_bits;  // saturating count of low bit times
   reg [2:0]  falls;     // falling edges seen in the sync character
   reg [18:0] span;      // clocks since the start-bit edge
   wire       fall;

   assign fall = rx_prev & ~rx;

   // break: at least eleven low bit times, ended by the rising edge
   always @(posedge sys_clk) begin
      if (rst) begin
         rx_prev  <= 1'b1;
         low_bits <= 5'h00;
         brk_seen <= 1'b0;
      end else begin
         rx_prev  <= rx;
         brk_seen <= 1'b0;
         if (rx) begin
            if (in_wait && low_bits >= `LMC_BRK_DETECT)
               brk_seen <= 1'b1;
            low_bits <= 5'h00;
         end else if (bit_tick && low_bits != 5'h1F) begin
            low_bits <= low_bits + 5'h01;
         end
      end
   end

   // sync 0x55 gives five falling edges eight bit times apart end to end;
   // the eight-bit span divided by eight averages out edge jitter
   always @(posedge sys_clk) begin
      if (rst) begin
         falls     <= 3'h0;
         span      <= 19'h00000;
         ab_done   <= 1'b0;
         ab_period <= `LMC_RST_RLD;
      end else begin
         ab_done <= 1'b0;
         if (!in_ab) begin
            falls <= 3'h0;
            span  <= 19'h00000;
         end else if (fall) begin
            if (falls == 3'h0) begin
               span <= 19'h00001;
            end else begin
               span <= span + 19'h00001;
            end
            if (falls == `LMC_SYNC_FALLS) begin
               ab_done   <= 1'b1;
               ab_period <= span[18:3];
               falls     <= 3'h0;
            end else begin
               falls <= falls + 3'h1;
            end
         end else if (falls != 3'h0 && span != 19'h7FFFF) begin
            span <= span + 19'h00001;
         end
      end
   end
endmodule

// ==== hdl/lmc_top.v ====
// Design decision made here: the Wishbone register port.
`timescale 1ns/1ps
`include "lmc_map.vh"
module lmc_top (
   // clock and reset
   input  wire        sys_clk,
   input  wire        rst,
   // wishbone slave
   input  wire        wb_cyc_i,
   input  wire        wb_stb_i,
   input  wire        wb_we_i,
   input  wire [13:2] wb_adr_i,
   input  wire [3:0]  wb_sel_i,
   input  wire [31:0] wb_dat_i,
   output reg  [31:0] wb_dat_o,
   output reg         wb_ack_o,
   // lin line
   input  wire        lin_rx,
   output wire        lin_tx,
   // core datapath requests
   input  wire        break_req,
   // status towards the core and the interrupt controller
   output reg         master_mode,
   output reg         slave_mode,
   output reg  [1:0]  bus_state,
   output reg         rx_nodata_irq,
   output reg         irq
);
   // register file
   reg  [7:0]  ctl0;            // multiproc, parity, page select
   reg  [7:0]  ctl1;            // lin control, state field kept apart
   reg  [2:0]  stat;            // sticky event bits
   reg  [2:0]  mask;            // interrupt mask, same layout
   reg  [15:0] reload;          // bit period reload value
   // line synchroniser
   reg         rx_meta;         // first stage, read by rx_sync only
   reg         rx_sync;
   // bit-rate divider
   reg  [15:0] div_cnt;
   reg         bit_tick;        // one-cycle pulse per bit time
   // decode
   wire        req;             // new bus request this cycle
   wire        wr;
   wire        lane0;           // low byte lane enabled
   wire        sel_ctl1;        // lin page is selected
   wire        multiproc_enable;
   wire        parity_enable;
   wire        master_role_select;
   wire        slave_role_select;
   wire        auto_rate_enable;
   wire        auto_rate_irq_enable;
   wire [1:0]  brk_len;
   wire        next_master;
   wire        next_slave;
   wire        ab_active;
   // helper outputs
   wire        brk_busy;
   wire        brk_done;
   wire        brk_seen;
   wire        ab_done;
   wire [15:0] ab_period;
   // state machine
   reg  [1:0]  next_state;
   reg  [2:0]  next_stat;
   wire        sw_state_wr;
   wire        rld_wr;          // software writes either reload byte

   // bus decode; one wait state, ack lasts one cycle
   assign req   = wb_cyc_i & wb_stb_i & ~wb_ack_o;
   assign wr    = req & wb_we_i;
   assign lane0 = wb_sel_i[0];

   // control field views
   assign multiproc_enable    = ctl0[`LMC_C0_MULTIPROC_ENABLE];
   assign parity_enable     = ctl0[`LMC_C0_PEN];
   assign sel_ctl1 = (ctl0[`LMC_C0_SEL_HI:`LMC_C0_SEL_LO] == `LMC_PAGE_LIN);
   assign master_role_select    = ctl1[`LMC_C1_MST];
   assign slave_role_select    = ctl1[`LMC_C1_SLV];
   assign auto_rate_enable    = ctl1[`LMC_C1_AUTO_RATE_ENABLE];
   assign auto_rate_irq_enable   = ctl1[`LMC_C1_AUTO_RATE_IRQ_ENABLE];
   assign brk_len = ctl1[`LMC_C1_BRK_HI:`LMC_C1_BRK_LO];

   // role qualification: both bits set selects neither role
   assign next_master = master_role_select & ~slave_role_select & ~multiproc_enable & ~parity_enable;
   assign next_slave  = slave_role_select & ~master_role_select & ~multiproc_enable & ~parity_enable;
   // autobaud measurement only runs for a slave with it enabled
   assign ab_active   = slave_mode & auto_rate_enable & (bus_state == `LMC_S_AUTOBAUD);

   // software write of the state field through the lin page
   assign sw_state_wr = wr & lane0 & sel_ctl1 & (wb_adr_i == `LMC_IDX_CTL1);
   // reload byte write, used to restart the bit-time divider
   assign rld_wr = wr & lane0 &
                   ((wb_adr_i == `LMC_IDX_RLD_LO) | (wb_adr_i == `LMC_IDX_RLD_HI));

   // two-stage synchroniser for the asynchronous line
   always @(posedge sys_clk) begin
      if (rst) begin
         rx_meta <= 1'b1;
         rx_sync <= 1'b1;
      end else begin
         rx_meta <= lin_rx;
         rx_sync <= rx_meta;
      end
   end

   // bit-time divider; restarts when a new period is loaded so the
   // first bit after autobaud is not stretched by a stale count
   always @(posedge sys_clk) begin
      if (rst) begin
         div_cnt  <= `LMC_RST_RLD;
         bit_tick <= 1'b0;
      end else begin
         bit_tick <= 1'b0;
         if (ab_done || div_cnt <= 16'h0001) begin
            div_cnt  <= ab_done ? ab_period : reload;
            bit_tick <= ~ab_done;
         end else if (rld_wr) begin
            // a software rate change restarts the count at once, else the
            // reset count of the full 16-bit range would delay the first bit
            div_cnt <= 16'h0001;
         end else begin
            div_cnt <= div_cnt - 16'h0001;
         end
      end
   end

   // master break transmitter
   lmc_brk u_brk (
      .sys_clk  (sys_clk),
      .rst      (rst),
      .start    (break_req & master_mode & (bus_state == `LMC_S_ACTIVE)),
      .len_sel  (brk_len),
      .bit_tick (bit_tick),
      .tx       (lin_tx),
      .busy     (brk_busy),
      .done     (brk_done)
   );

   // slave break detection and rate measurement
   lmc_abd u_abd (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .rx        (rx_sync),
      .in_wait   (slave_mode & (bus_state == `LMC_S_WAITBRK)),
      .in_ab     (ab_active),
      .bit_tick  (bit_tick),
      .brk_seen  (brk_seen),
      .ab_done   (ab_done),
      .ab_period (ab_period)
   );

   // next lin state: software write wins over hardware sequencing
   always @* begin
      next_state = bus_state;
      if (sw_state_wr) begin
         next_state = wb_dat_i[`LMC_C1_ST_HI:`LMC_C1_ST_LO];
      end else if (slave_mode) begin
         case (bus_state)
            `LMC_S_WAITBRK: begin
               // without autobaud the rate is already known
               if (brk_seen)
                  next_state = auto_rate_enable ? `LMC_S_AUTOBAUD : `LMC_S_ACTIVE;
            end
            `LMC_S_AUTOBAUD: begin
               if (ab_done)
                  next_state = `LMC_S_ACTIVE;
               else if (!auto_rate_enable)
                  next_state = `LMC_S_ACTIVE;
            end
            default: begin
               next_state = bus_state;
            end
         endcase
      end else begin
         // master and unqualified roles hold whatever software wrote
         next_state = bus_state;
      end
   end

   // lin state register and role flags
   always @(posedge sys_clk) begin
      if (rst) begin
         bus_state   <= `LMC_S_SLEEP;
         master_mode <= 1'b0;
         slave_mode  <= 1'b0;
      end else begin
         bus_state   <= next_state;
         master_mode <= next_master;
         slave_mode  <= next_slave;
      end
   end

   // sticky status: a hardware set in the clearing cycle survives
   always @* begin
      next_stat = stat;
      if (wr && lane0 && wb_adr_i == `LMC_IDX_STAT)
         next_stat = stat & ~wb_dat_i[`LMC_ST_W-1:0];
      if (ab_done && auto_rate_irq_enable)
         next_stat[`LMC_ST_ABDONE] = 1'b1;
      if (brk_done)
         next_stat[`LMC_ST_BRKSENT] = 1'b1;
      if (brk_seen)
         next_stat[`LMC_ST_BRKSEEN] = 1'b1;
   end

   // register writes
   always @(posedge sys_clk) begin
      if (rst) begin
         ctl0   <= `LMC_RST_CTL;
         ctl1   <= `LMC_RST_CTL;
         stat   <= 3'h0;
         mask   <= 3'h0;
         reload <= `LMC_RST_RLD;
      end else begin
         stat <= next_stat;
         if (ab_done) begin
            reload <= ab_period;
         end
         if (wr && lane0) begin
            case (wb_adr_i)
               `LMC_IDX_CTL0: begin
                  ctl0 <= wb_dat_i[7:0];
               end
               `LMC_IDX_CTL1: begin
                  // other pages of this address are not held here
                  if (sel_ctl1)
                     ctl1 <= wb_dat_i[7:0];
               end
               `LMC_IDX_MASK: begin
                  mask <= wb_dat_i[`LMC_ST_W-1:0];
               end
               `LMC_IDX_RLD_LO: begin
                  if (!ab_done)
                     reload[7:0] <= wb_dat_i[7:0];
               end
               `LMC_IDX_RLD_HI: begin
                  if (!ab_done)
                     reload[15:8] <= wb_dat_i[7:0];
               end
               default: begin
                  ctl0 <= ctl0;
               end
            endcase
         end
      end
   end

   // read mux and ack; unmapped reads return zero and still ack
   always @(posedge sys_clk) begin
      if (rst) begin
         wb_ack_o <= 1'b0;
         wb_dat_o <= 32'h00000000;
      end else begin
         wb_ack_o <= req;
         wb_dat_o <= 32'h00000000;
         if (req && !wb_we_i) begin
            case (wb_adr_i)
               `LMC_IDX_CTL0: begin
                  wb_dat_o[7:0] <= ctl0;
               end
               `LMC_IDX_CTL1: begin
                  // state field shows the live machine state
                  if (sel_ctl1)
                     wb_dat_o[7:0] <= {ctl1[7:4], bus_state, ctl1[1:0]};
               end
               `LMC_IDX_STAT: begin
                  wb_dat_o[7:0] <= {4'h0, brk_busy, stat};
               end
               `LMC_IDX_MASK: begin
                  wb_dat_o[7:0] <= {5'h00, mask};
               end
               `LMC_IDX_RLD_HI: begin
                  wb_dat_o[7:0] <= reload[15:8];
               end
               `LMC_IDX_RLD_LO: begin
                  wb_dat_o[7:0] <= reload[7:0];
               end
               default: begin
                  wb_dat_o <= 32'h00000000;
               end
            endcase
         end
      end
   end

   // interrupt outputs; irq follows the status value being registered
   always @(posedge sys_clk) begin
      if (rst) begin
         irq           <= 1'b0;
         rx_nodata_irq <= 1'b0;
      end else begin
         irq           <= |(next_stat & mask);
         rx_nodata_irq <= ab_done & auto_rate_irq_enable & slave_mode & auto_rate_enable;
      end
   end
endmodule

// ==== sim/lmc_monitor.sv ====
`timescale 1ns/1ps
// port-level checks of the lin control block
module lmc_monitor (
   // clock and reset
   input wire        sys_clk,
   input wire        rst,
   // register bus
   input wire        wb_cyc_i,
   input wire        wb_stb_i,
   input wire [31:0] wb_dat_o,
   input wire        wb_ack_o,
   // lin side
   input wire        lin_tx,
   input wire        master_mode,
   input wire        slave_mode,
   input wire [1:0]  bus_state,
   input wire        rx_nodata_irq
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (rst);
   chk_ack_follows: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("request not acked next cycle");
   chk_ack_pulse: assert property (wb_ack_o |-> $past(wb_cyc_i) && $past(wb_stb_i) ##1 !wb_ack_o)
      else $error("ack without request or too long");
   chk_dat_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h00000000)
      else $error("read data not zero outside ack");
   chk_role_one: assert property (!(master_mode && slave_mode))
      else $error("both roles active");
   chk_brk_start: assert property ($fell(lin_tx) |-> $past(master_mode) && $past(bus_state) == 2'h3)
      else $error("break outside master active");
   chk_brk_hold: assert property ($fell(lin_tx) |-> !lin_tx [*8])
      else $error("break too short");
   chk_abd_pulse: assert property (rx_nodata_irq |=> !rx_nodata_irq)
      else $error("autobaud interrupt not a pulse");
   chk_abd_slave: assert property (rx_nodata_irq |-> $past(slave_mode) ##[0:1] bus_state == 2'h3)
      else $error("autobaud interrupt outside slave");
endmodule
bind lmc_top lmc_monitor u_mon (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .lin_tx(lin_tx),
   .master_mode(master_mode), .slave_mode(slave_mode), .bus_state(bus_state),
   .rx_nodata_irq(rx_nodata_irq));

// ==== sim/lmc_lin_node.sv ====
`timescale 1ns/1ps
// remote lin master seen by our slave: break, delimiter, sync byte
module lmc_lin_node (
   // clock
   input wire   sys_clk,
   // line towards the block
   output logic rx
);
   initial rx = 1'b1; // pull-up keeps the idle bus recessive
   // drive a level for n bit times, changing only after an edge
   task automatic hold(input logic v, input int n, input int bt);
      rx <= v;
      repeat (n * bt) @(posedge sys_clk);
   endtask
   // thirteen-bit break, delimiter, start bit, then 0x55 lsb first
   task automatic send_header(input int bt);
      int i;
      hold(1'b0, 13, bt);
      hold(1'b1, 1, bt);
      hold(1'b0, 1, bt);
      for (i = 0; i < 8; i++) begin
         hold(!i[0], 1, bt);
      end
      hold(1'b1, 2, bt); // stop bit and idle tail
   endtask
endmodule

// ==== sim/lmc_top_tb_top.sv ====
`timescale 1ns/1ps
`include "lmc_map.vh"
// self-checking bench for the lin control block
module lmc_top_tb_top;
   logic        sys_clk = 1'b0;
   logic        rst = 1'b1;
   logic        cyc = 1'b0;
   logic        stb = 1'b0;
   logic        we = 1'b0;
   logic [11:0] adr = 12'h000;
   logic [3:0]  sel = 4'h0;
   logic [31:0] wdat = 32'h00000000;
   logic [31:0] rdat;
   logic        ack, lin_tx, lin_rx, brk_req = 1'b0;
   logic        mst, slv, irq, abirq;
   logic [1:0]  st;
   logic [31:0] seed = 32'hA358;  // lfsr state
   logic [7:0]  q;
   int          n_mismatch = 0;
   int          n_compared = 0;
   int          n_abirq = 0;      // autobaud interrupt pulses seen
   int          m_page = 0;       // model of the page select
   int          bt, rl, c, i, n, k;
   logic [7:0]  t0 [7] = '{8'h02, 8'h42, 8'h82, 8'h02, 8'h42, 8'h82, 8'h02};
   logic [7:0]  t1 [7] = '{8'h80, 8'h80, 8'h80, 8'h40, 8'h40, 8'h40, 8'hC0};
   logic [1:0]  tm [7] = '{2'h2, 2'h0, 2'h0, 2'h1, 2'h0, 2'h0, 2'h0};

   always #10 sys_clk = ~sys_clk;
   always @(posedge sys_clk) if (abirq === 1'b1) n_abirq <= n_abirq + 1;

   lmc_top u_lmc_top (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
      .wb_ack_o(ack), .lin_rx(lin_rx), .lin_tx(lin_tx), .break_req(brk_req),
      .master_mode(mst), .slave_mode(slv), .bus_state(st), .rx_nodata_irq(abirq),
      .irq(irq));
   lmc_lin_node u_lmc_lin_node (.sys_clk(sys_clk), .rx(lin_rx));

   function logic [31:0] lfsr(input logic [31:0] s);
      lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   task stop_test;
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // one classic cycle, held until ack is sampled, then one idle cycle
   task bus(input logic w, input logic [11:0] a, input logic [7:0] d);
      int t;
      t = 0;
      cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; sel <= 4'hF; wdat <= {24'h000000, d};
      do begin @(posedge sys_clk); t++; end while (ack !== 1'b1 && t < 50);
      if (t >= 50) chk("ack", 16'h0000, 16'h0001);
      q = rdat[7:0];
      cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
      @(posedge sys_clk);
   endtask
   task wr(input logic [11:0] a, input logic [7:0] d);
      bus(1'b1, a, d);
      if (a == `LMC_IDX_CTL0) m_page = d[2:0];
   endtask
   task rd(input string nm, input logic [11:0] a, input logic [7:0] exp);
      bus(1'b0, a, 8'h00);
      // the lin register reads zero while another page is selected
      if (a == `LMC_IDX_CTL1 && m_page != 2) chk(nm, {8'h00, q}, 16'h0000);
      else chk(nm, {8'h00, q}, {8'h00, exp});
   endtask
   task wait_st(input logic [1:0] v, input int lim);
      k = 0;
      while (st !== v && k < lim) begin @(posedge sys_clk); k++; end
      chk("state", {14'h0000, st}, {14'h0000, v});
   endtask

   // watchdog: the whole run needs a little over a thousand cycles
   initial begin
      #400000;
      n_mismatch++;
      stop_test;
   end

   initial begin
      repeat (10) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      seed = lfsr(seed);
      bt = 12 + seed[3:0];
      rl = 2 + seed[5:4];
      // reset values and an unmapped index
      wr(`LMC_IDX_CTL0, 8'h02);
      rd("ctl1", `LMC_IDX_CTL1, 8'h00);
      rd("rld_hi", `LMC_IDX_RLD_HI, 8'hFF);
      rd("rld_lo", `LMC_IDX_RLD_LO, 8'hFF);
      wr(12'h100, 8'hA5);
      rd("unmapped", 12'h100, 8'h00);
      // other page hides the lin register and drops writes
      wr(`LMC_IDX_CTL0, 8'h01);
      wr(`LMC_IDX_CTL1, 8'hFF);
      rd("ctl1_hidden", `LMC_IDX_CTL1, 8'h00);
      wr(`LMC_IDX_CTL0, 8'h02);
      rd("ctl1_kept", `LMC_IDX_CTL1, 8'h00);
      // role qualification table
      for (i = 0; i < 7; i++) begin
         wr(`LMC_IDX_CTL0, t0[i]);
         wr(`LMC_IDX_CTL1, t1[i]);
         chk("roles", {14'h0000, mst, slv}, {14'h0000, tm[i]});
      end
      // master breaks of every length code
      wr(`LMC_IDX_CTL0, 8'h02);
      wr(`LMC_IDX_RLD_HI, 8'h00);
      wr(`LMC_IDX_RLD_LO, 8'(rl));
      for (c = 0; c < 4; c++) begin
         wr(`LMC_IDX_CTL1, 8'h8C | 8'(c));
         chk("master", {14'h0000, mst, st[1]}, 16'h0003);
         brk_req <= 1'b1;
         @(posedge sys_clk);
         brk_req <= 1'b0;
         k = 0;
         n = 0;
         while (lin_tx !== 1'b0 && k < 5) begin @(posedge sys_clk); k++; end
         while (lin_tx === 1'b0 && n < 400) begin @(posedge sys_clk); n++; end
         chk("brk_len", 16'(n > (12 + c) * rl && n <= (13 + c) * rl + 1), 16'h0001);
         rd("brk_sent", `LMC_IDX_STAT, 8'h02);
      end
      chk("irq_masked", {15'h0000, irq}, 16'h0000);
      wr(`LMC_IDX_MASK, 8'h02);
      chk("irq_set", {15'h0000, irq}, 16'h0001);
      wr(`LMC_IDX_STAT, 8'h02);
      chk("irq_clr", {15'h0000, irq}, 16'h0000);
      chk("active_kept", {14'h0000, st}, 16'h0003);
      wr(`LMC_IDX_CTL1, 8'h80);
      chk("sleep", {14'h0000, st}, 16'h0000);
      // slave autobaud on a header from the remote master
      wr(`LMC_IDX_RLD_LO, 8'h04);
      wr(`LMC_IDX_MASK, 8'h01);
      wr(`LMC_IDX_CTL1, 8'h74);
      chk("wait_brk", {14'h0000, slv, st[0]}, 16'h0003);
      fork
         u_lmc_lin_node.send_header(bt);
         wait_st(2'h2, 4000);
      join
      wait_st(2'h3, 200);
      chk("abd_irq", 16'(n_abirq), 16'h0001);
      chk("irq_abd", {15'h0000, irq}, 16'h0001);
      rd("rld_hi", `LMC_IDX_RLD_HI, 8'(bt >> 8));
      rd("rld_lo", `LMC_IDX_RLD_LO, 8'(bt));
      // autobaud done plus the break seen before the sync character
      rd("abd_flag", `LMC_IDX_STAT, 8'h05);
      wr(`LMC_IDX_STAT, 8'h01);
      chk("irq_off", {15'h0000, irq}, 16'h0000);
      // autobaud off: no measurement, no interrupt, straight to active
      wr(`LMC_IDX_CTL1, 8'h44);
      wait_st(2'h1, 2);
      u_lmc_lin_node.send_header(bt + 3);
      wait_st(2'h3, 200);
      chk("abd_none", 16'(n_abirq), 16'h0001);
      rd("rld_same", `LMC_IDX_RLD_LO, 8'(bt));
      wr(`LMC_IDX_CTL1, 8'h40);
      chk("forced", {14'h0000, st}, 16'h0000);
      stop_test;
   end
endmodule
